// file: sfd_decoder.sv
// serial flash opcode decoder with command admission during busy phases
//
// Functional notes
// - class A: page, continuous and register reads
// - class B: four erases, then six buffer operations
// - class C: buffer read/write, status, identification
// - class D: protection erase/program, lockdown, security program
// - erase busy: any class C command allowed
// - class B 5-10 busy: only status, identification
// - 03H slow, 0BH fast continuous read
// - D2H page read, E8H old continuous read
// - D1H slow buffer read, D4H buffer read
// - 83H program with erase, 88H without
// - 84H buffer write, 82H program through buffer
// - 3D 2A 7F A9/9A protection enable/disable
// - prefix plus CF/FC erase/program protection register
// - prefix plus 30H is sector lockdown
// - 9B 00 00 00 programs security register
// - 32H, 35H, 77H register reads
// - 53H transfer, 60H compare, 58H rewrite
// - B9H deep power-down, ABH resume
// - D7H status read, 9FH identification read
// - older 54H, 52H, 68H, 57H still accepted
`timescale 1ns/1ps
`include "sfd_defines.svh"

module sfd_decoder
    import sfd_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    // system clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // serial link from the host
    input  wire logic             link_sck,
    input  wire logic             link_cs_n,
    input  wire logic             link_si,
    // device core
    input  wire logic             op_done,
    // decoded command
    output sfd_cmd_t              cmd,
    output logic                  cmd_valid,
    output logic [ADDR_W-1:0]     addr,
    output logic                  addr_valid,
    // execution at frame end
    output logic                  cmd_exec,
    output sfd_op_t               exec_op,
    output sfd_busy_t             busy,
    output logic                  power_down
);

    if (ADDR_W < 1 || ADDR_W > `SFD_ADDR_MAX_W)
    begin : g_bad_addr
        $error("ADDR_W must lie between 1 and 24");
    end

    // ******
    // link side: shift in the first four bytes
    // ******
    sfd_link_st_t lk;
    sfd_link_st_t next_lk;

    // kept bytes change once per frame; the synced toggle hands them over
    always_comb
    begin
        next_lk = lk;
        next_lk.shift = {lk.shift[5:0], link_si};
        next_lk.bit_cnt = lk.bit_cnt + 3'h1;
        if (lk.bit_cnt == `SFD_LAST_BIT && lk.byte_idx < `SFD_BYTES_KEPT)
        begin
            next_lk.bytes[lk.byte_idx[1:0]] = {lk.shift, link_si};
            next_lk.byte_idx = lk.byte_idx + 3'h1;
            next_lk.tog = ~lk.tog;
        end
    end

    // chip select high clears the link logic as sck may stop between
    // frames; select must stay low until the last byte has crossed
    always_ff @(posedge link_sck or posedge link_cs_n)
    begin
        if (link_cs_n)
            lk <= '0;
        else
            lk <= next_lk;
    end

    // ******
    // decode helpers
    // ******
    function automatic sfd_op_t decode_single(input logic [7:0] b);
        sfd_op_t o;
        case (b)
            `SFD_OP_CONT_READ_LF:  o = SFD_CONT_READ_LF;
            `SFD_OP_CONT_READ_HF:  o = SFD_CONT_READ_HF;
            `SFD_OP_PAGE_READ:     o = SFD_PAGE_READ;
            `SFD_OP_CONT_READ_OLD: o = SFD_CONT_READ_OLD;
            `SFD_OP_BUF_READ_LF:   o = SFD_BUF_READ_LF;
            `SFD_OP_BUF_READ:      o = SFD_BUF_READ;
            `SFD_OP_PROG_ERASE:    o = SFD_PROG_ERASE;
            `SFD_OP_PROG_NOERASE:  o = SFD_PROG_NOERASE;
            `SFD_OP_BUF_WRITE:     o = SFD_BUF_WRITE;
            `SFD_OP_PROG_THRU_BUF: o = SFD_PROG_THRU_BUF;
            `SFD_OP_PROT_READ:     o = SFD_PROT_READ;
            `SFD_OP_LOCK_READ:     o = SFD_LOCK_READ;
            `SFD_OP_SEC_READ:      o = SFD_SEC_READ;
            `SFD_OP_XFER:          o = SFD_XFER;
            `SFD_OP_COMPARE:       o = SFD_COMPARE;
            `SFD_OP_REWRITE:       o = SFD_REWRITE;
            `SFD_OP_POWER_DOWN:    o = SFD_POWER_DOWN;
            `SFD_OP_RESUME:        o = SFD_RESUME;
            `SFD_OP_STATUS_READ:   o = SFD_STATUS_READ;
            `SFD_OP_ID_READ:       o = SFD_ID_READ;
            `SFD_OP_OLD_BUF_READ:  o = SFD_BUF_READ;
            `SFD_OP_OLD_PAGE_READ: o = SFD_PAGE_READ;
            `SFD_OP_OLD_CONT_READ: o = SFD_CONT_READ_OLD;
            `SFD_OP_OLD_STATUS:    o = SFD_STATUS_READ;
            `SFD_OP_PAGE_ERASE:    o = SFD_PAGE_ERASE;
            `SFD_OP_BLOCK_ERASE:   o = SFD_BLOCK_ERASE;
            default:               o = SFD_UNKNOWN;
        endcase
        return o;
    endfunction

    function automatic sfd_op_t decode_seq(input logic [7:0] b0,
                                           input logic [7:0] b1,
                                           input logic [7:0] b2,
                                           input logic [7:0] b3);
        sfd_op_t o;
        o = SFD_UNKNOWN;
        if (b0 == `SFD_SEQ_PROT_B0 && b1 == `SFD_SEQ_PROT_B1
            && b2 == `SFD_SEQ_PROT_B2)
        begin
            case (b3)
                `SFD_SEQ_PROT_EN:    o = SFD_PROT_EN;
                `SFD_SEQ_PROT_DIS:   o = SFD_PROT_DIS;
                `SFD_SEQ_PROT_ERASE: o = SFD_PROT_ERASE;
                `SFD_SEQ_PROT_PROG:  o = SFD_PROT_PROG;
                `SFD_SEQ_LOCKDOWN:   o = SFD_LOCKDOWN;
                default:             o = SFD_UNKNOWN;
            endcase
        end
        else if (b0 == `SFD_SEQ_SEC_B0 && b1 == `SFD_SEQ_SEC_TAIL
                 && b2 == `SFD_SEQ_SEC_TAIL && b3 == `SFD_SEQ_SEC_TAIL)
            o = SFD_SEC_PROG;
        // chip erase or sector erase with address
        else if (b0 == `SFD_OP_SECTOR_ERASE)
        begin
            if (b1 == `SFD_SEQ_CHIP_B1 && b2 == `SFD_SEQ_CHIP_B2
                && b3 == `SFD_SEQ_CHIP_B3)
                o = SFD_CHIP_ERASE;
            else
                o = SFD_SECTOR_ERASE;
        end
        return o;
    endfunction

    function automatic sfd_grp_t group_of(input sfd_op_t o);
        sfd_grp_t g;
        case (o)
            SFD_PAGE_READ, SFD_CONT_READ_OLD, SFD_CONT_READ_LF,
            SFD_CONT_READ_HF, SFD_PROT_READ, SFD_LOCK_READ,
            SFD_SEC_READ:
                g = SFD_GRP_A;
            SFD_PAGE_ERASE, SFD_BLOCK_ERASE, SFD_SECTOR_ERASE,
            SFD_CHIP_ERASE:
                g = SFD_GRP_B_ERASE;
            SFD_XFER, SFD_COMPARE, SFD_PROG_ERASE, SFD_PROG_NOERASE,
            SFD_PROG_THRU_BUF, SFD_REWRITE:
                g = SFD_GRP_B_XFER;
            SFD_BUF_READ_LF, SFD_BUF_READ, SFD_BUF_WRITE,
            SFD_STATUS_READ, SFD_ID_READ:
                g = SFD_GRP_C;
            SFD_PROT_ERASE, SFD_PROT_PROG, SFD_LOCKDOWN, SFD_SEC_PROG:
                g = SFD_GRP_D;
            default:
                g = SFD_GRP_OTHER;
        endcase
        return g;
    endfunction

    function automatic logic [2:0] dummy_of(input sfd_op_t o);
        logic [2:0] d;
        case (o)
            SFD_CONT_READ_HF, SFD_BUF_READ:  d = `SFD_DUMMY_FAST;
            SFD_PAGE_READ, SFD_CONT_READ_OLD: d = `SFD_DUMMY_PAGE;
            default:                          d = `SFD_DUMMY_NONE;
        endcase
        return d;
    endfunction

    function automatic logic admit(input sfd_op_t o, input sfd_busy_t bz,
                                   input logic pd);
        logic ok;
        if (o == SFD_UNKNOWN)
            ok = 1'b0;
        // asleep, only the resume opcode wakes the device
        else if (pd)
            ok = (o == SFD_RESUME);
        else if (o == SFD_RESUME)
            ok = 1'b0;
        else
        begin
            case (bz)
                SFD_BUSY_ERASE: ok = (group_of(o) == SFD_GRP_C);
                SFD_BUSY_XFER:  ok = (o == SFD_STATUS_READ
                                      || o == SFD_ID_READ);
                SFD_BUSY_PROT:  ok = (o == SFD_STATUS_READ);
                default:        ok = 1'b1;
            endcase
        end
        return ok;
    endfunction

    function automatic logic needs_seq(input logic [7:0] b);
        return b == `SFD_SEQ_PROT_B0 || b == `SFD_SEQ_SEC_B0
               || b == `SFD_OP_SECTOR_ERASE;
    endfunction

    // ******
    // system side: decode, admit, execute
    // ******
    sfd_sys_st_t s;
    sfd_sys_st_t next_s;
    logic [7:0]  byte_in;
    sfd_op_t     op_now;

    always_comb
    begin
        next_s = s;
        byte_in = lk.bytes[s.byte_cnt[1:0]];
        op_now = SFD_NONE;
        next_s.cs_meta = link_cs_n;
        next_s.cs_sync = s.cs_meta;
        next_s.tog_meta = lk.tog;
        next_s.tog_sync = s.tog_meta;
        next_s.cmd_valid = 1'b0;
        next_s.addr_valid = 1'b0;
        next_s.cmd_exec = 1'b0;
        if (op_done)
            next_s.busy = SFD_IDLE;
        if (s.cs_sync)
        begin
            next_s.last_tog = 1'b0;
            next_s.byte_cnt = 3'h0;
            next_s.frame_act = 1'b0;
            next_s.exec_pend = 1'b0;
            // self-timed work starts only once chip select rises
            if (s.frame_act && s.exec_pend)
            begin
                next_s.cmd_exec = 1'b1;
                next_s.exec_op = s.cmd.op;
                if (s.cmd.grp == SFD_GRP_B_ERASE)
                    next_s.busy = SFD_BUSY_ERASE;
                else if (s.cmd.grp == SFD_GRP_B_XFER)
                    next_s.busy = SFD_BUSY_XFER;
                else if (s.cmd.grp == SFD_GRP_D)
                    next_s.busy = SFD_BUSY_PROT;
                if (s.cmd.op == SFD_POWER_DOWN)
                    next_s.power_down = 1'b1;
                else if (s.cmd.op == SFD_RESUME)
                    next_s.power_down = 1'b0;
            end
        end
        else
        begin
            next_s.frame_act = 1'b1;
            if (s.tog_sync != s.last_tog && s.byte_cnt < `SFD_BYTES_KEPT)
            begin
                next_s.last_tog = s.tog_sync;
                next_s.byte_cnt = s.byte_cnt + 3'h1;
                case (s.byte_cnt)
                    3'h0:
                    begin
                        next_s.b0 = byte_in;
                        if (!needs_seq(byte_in))
                            op_now = decode_single(byte_in);
                    end
                    3'h1: next_s.b1 = byte_in;
                    3'h2: next_s.b2 = byte_in;
                    default:
                    begin
                        next_s.addr = {s.b1, s.b2, byte_in};
                        next_s.addr_valid = 1'b1;
                        if (needs_seq(s.b0))
                            op_now = decode_seq(s.b0, s.b1, s.b2, byte_in);
                    end
                endcase
            end
            if (op_now != SFD_NONE)
            begin
                next_s.cmd.op = op_now;
                next_s.cmd.grp = group_of(op_now);
                next_s.cmd.dummy = dummy_of(op_now);
                next_s.cmd.accepted = admit(op_now, s.busy, s.power_down);
                next_s.cmd_valid = 1'b1;
                // reads run inside the frame; the rest run after it
                next_s.exec_pend = next_s.cmd.accepted
                    && group_of(op_now) != SFD_GRP_A
                    && (group_of(op_now) != SFD_GRP_C
                        || op_now == SFD_BUF_WRITE);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.cs_meta <= 1'b1;
            s.cs_sync <= 1'b1;
        end
        else
            s <= next_s;
    end

    // ******
    // outputs
    // ******
    assign cmd        = s.cmd;
    assign cmd_valid  = s.cmd_valid;
    assign addr       = s.addr[ADDR_W-1:0];
    assign addr_valid = s.addr_valid;
    assign cmd_exec   = s.cmd_exec;
    assign exec_op    = s.exec_op;
    assign busy       = s.busy;
    assign power_down = s.power_down;

endmodule

// file: sfd_defines.svh
// opcode values, field positions and dummy counts of the command decoder
`ifndef SFD_DEFINES_SVH
`define SFD_DEFINES_SVH

// ******
// single-byte opcodes
// ******
`define SFD_OP_PAGE_READ      8'hD2
`define SFD_OP_CONT_READ_OLD  8'hE8
`define SFD_OP_CONT_READ_LF   8'h03
`define SFD_OP_CONT_READ_HF   8'h0B
`define SFD_OP_BUF_READ_LF    8'hD1
`define SFD_OP_BUF_READ       8'hD4
`define SFD_OP_BUF_WRITE      8'h84
`define SFD_OP_PROG_ERASE     8'h83
`define SFD_OP_PROG_NOERASE   8'h88
`define SFD_OP_PAGE_ERASE     8'h81
`define SFD_OP_BLOCK_ERASE    8'h50
`define SFD_OP_SECTOR_ERASE   8'h7C
`define SFD_OP_PROG_THRU_BUF  8'h82
`define SFD_OP_PROT_READ      8'h32
`define SFD_OP_LOCK_READ      8'h35
`define SFD_OP_SEC_READ       8'h77
`define SFD_OP_XFER           8'h53
`define SFD_OP_COMPARE        8'h60
`define SFD_OP_REWRITE        8'h58
`define SFD_OP_POWER_DOWN     8'hB9
`define SFD_OP_RESUME         8'hAB
`define SFD_OP_STATUS_READ    8'hD7
`define SFD_OP_ID_READ        8'h9F

// ******
// older opcodes still served
// ******
`define SFD_OP_OLD_BUF_READ   8'h54
`define SFD_OP_OLD_PAGE_READ  8'h52
`define SFD_OP_OLD_CONT_READ  8'h68
`define SFD_OP_OLD_STATUS     8'h57

// ******
// four-byte sequences
// ******
`define SFD_SEQ_PROT_B0       8'h3D
`define SFD_SEQ_PROT_B1       8'h2A
`define SFD_SEQ_PROT_B2       8'h7F
`define SFD_SEQ_PROT_EN       8'hA9
`define SFD_SEQ_PROT_DIS      8'h9A
`define SFD_SEQ_PROT_ERASE    8'hCF
`define SFD_SEQ_PROT_PROG     8'hFC
`define SFD_SEQ_LOCKDOWN      8'h30
`define SFD_SEQ_SEC_B0        8'h9B
`define SFD_SEQ_SEC_TAIL      8'h00
`define SFD_SEQ_CHIP_B1       8'h94
`define SFD_SEQ_CHIP_B2       8'h80
`define SFD_SEQ_CHIP_B3       8'h9A

// ******
// framing and address layout
// ******
`define SFD_BYTES_KEPT        3'h4
`define SFD_LAST_BIT          3'h7
`define SFD_ADDR_MAX_W        24
`define SFD_DUMMY_FAST        3'h1
`define SFD_DUMMY_PAGE        3'h4
`define SFD_DUMMY_NONE        3'h0

`endif

// file: sfd_pkg.sv
// types shared by the serial flash command decoder
package sfd_pkg;

    typedef enum logic [4:0] {
        SFD_NONE, SFD_PAGE_READ, SFD_CONT_READ_OLD, SFD_CONT_READ_LF,
        SFD_CONT_READ_HF, SFD_BUF_READ_LF, SFD_BUF_READ, SFD_BUF_WRITE,
        SFD_PROG_ERASE, SFD_PROG_NOERASE, SFD_PAGE_ERASE, SFD_BLOCK_ERASE,
        SFD_SECTOR_ERASE, SFD_CHIP_ERASE, SFD_PROG_THRU_BUF, SFD_PROT_EN,
        SFD_PROT_DIS, SFD_PROT_ERASE, SFD_PROT_PROG, SFD_PROT_READ,
        SFD_LOCKDOWN, SFD_LOCK_READ, SFD_SEC_PROG, SFD_SEC_READ, SFD_XFER,
        SFD_COMPARE, SFD_REWRITE, SFD_POWER_DOWN, SFD_RESUME,
        SFD_STATUS_READ, SFD_ID_READ, SFD_UNKNOWN
    } sfd_op_t;

    // class b is split: erases (members 1-4) and transfers/programs (5-10)
    typedef enum logic [2:0] {
        SFD_GRP_A, SFD_GRP_B_ERASE, SFD_GRP_B_XFER, SFD_GRP_C, SFD_GRP_D,
        SFD_GRP_OTHER
    } sfd_grp_t;

    typedef enum logic [1:0] {
        SFD_IDLE, SFD_BUSY_ERASE, SFD_BUSY_XFER, SFD_BUSY_PROT
    } sfd_busy_t;

    typedef struct packed {
        sfd_op_t    op;
        sfd_grp_t   grp;
        logic [2:0] dummy;
        logic       accepted;
    } sfd_cmd_t;

    typedef struct packed {
        logic [2:0]      bit_cnt;
        logic [2:0]      byte_idx;
        logic [6:0]      shift;
        logic [3:0][7:0] bytes;
        logic            tog;
    } sfd_link_st_t;

    typedef struct packed {
        logic       cs_meta;
        logic       cs_sync;
        logic       tog_meta;
        logic       tog_sync;
        logic       last_tog;
        logic       frame_act;
        logic [2:0] byte_cnt;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic       exec_pend;
        sfd_cmd_t   cmd;
        logic       cmd_valid;
        logic [23:0] addr;
        logic       addr_valid;
        logic       cmd_exec;
        sfd_op_t    exec_op;
        sfd_busy_t  busy;
        logic       power_down;
    } sfd_sys_st_t;

endpackage

// file: sfd_decoder_assertions.sv
// port-level checks of the serial flash command decoder
`timescale 1ns/1ps
module sfd_decoder_assertions
    import sfd_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    // clock and reset
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    // link and core
    input wire logic              link_sck,
    input wire logic              link_cs_n,
    input wire logic              link_si,
    input wire logic              op_done,
    // decoded command and execution
    input wire sfd_cmd_t          cmd,
    input wire logic              cmd_valid,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              addr_valid,
    input wire logic              cmd_exec,
    input wire sfd_op_t           exec_op,
    input wire sfd_busy_t         busy,
    input wire logic              power_down
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    logic rda, ers, prt, rdx;
    assign rda = cmd.op inside {SFD_PAGE_READ, SFD_CONT_READ_OLD,
        SFD_CONT_READ_LF, SFD_CONT_READ_HF, SFD_PROT_READ, SFD_LOCK_READ,
        SFD_SEC_READ};
    assign ers = exec_op inside {SFD_PAGE_ERASE, SFD_BLOCK_ERASE,
        SFD_SECTOR_ERASE, SFD_CHIP_ERASE};
    assign prt = exec_op inside {SFD_PROT_ERASE, SFD_PROT_PROG, SFD_LOCKDOWN,
        SFD_SEC_PROG};
    // reads end with the frame, so they are never executed
    assign rdx = exec_op inside {SFD_PAGE_READ, SFD_CONT_READ_OLD,
        SFD_CONT_READ_LF, SFD_CONT_READ_HF, SFD_PROT_READ, SFD_LOCK_READ,
        SFD_SEC_READ, SFD_BUF_READ_LF, SFD_BUF_READ, SFD_STATUS_READ,
        SFD_ID_READ};

    // ******
    // classes and admission
    // ******
    a_read_class: assert property (
        cmd_valid && rda |-> cmd.grp == SFD_GRP_A)
        else $error("read opcode not in class a");
    a_dummy_count: assert property (
        cmd_valid && cmd.op inside {SFD_CONT_READ_HF, SFD_BUF_READ}
        |-> cmd.dummy == 3'h1)
        else $error("fast read dummy count wrong");
    a_erase_busy: assert property (
        cmd_exec && ers |=> busy == SFD_BUSY_ERASE)
        else $error("erase did not start erase phase");
    a_prot_busy: assert property (
        cmd_exec && prt |=> busy == SFD_BUSY_PROT)
        else $error("class d did not start protect phase");
    a_done_idle: assert property (
        op_done |=> busy == SFD_IDLE || cmd_exec)
        else $error("busy not cleared by op_done");
    a_erase_admit: assert property (
        cmd_valid && busy == SFD_BUSY_ERASE && $past(busy) == SFD_BUSY_ERASE
        && cmd.grp == SFD_GRP_C |-> cmd.accepted)
        else $error("class c refused during erase");
    a_xfer_admit: assert property (
        cmd_valid && busy == SFD_BUSY_XFER && $past(busy) == SFD_BUSY_XFER
        |-> cmd.accepted == (cmd.op inside {SFD_STATUS_READ, SFD_ID_READ}))
        else $error("wrong admission during transfer phase");
    a_prot_admit: assert property (
        cmd_valid && busy == SFD_BUSY_PROT && $past(busy) == SFD_BUSY_PROT
        |-> cmd.accepted == (cmd.op == SFD_STATUS_READ))
        else $error("wrong admission during protect phase");
    a_read_noexec: assert property (
        cmd_exec |-> !rdx)
        else $error("read command executed");
    a_pd_entry: assert property (
        cmd_exec && exec_op == SFD_POWER_DOWN |-> ##[0:2] power_down)
        else $error("power-down not entered");
    a_addr_pulse: assert property (
        addr_valid |=> !addr_valid)
        else $error("address strobe longer than one cycle");

    c_chip: cover property (cmd_exec && exec_op == SFD_CHIP_ERASE);
    c_xfer: cover property (cmd_valid && busy == SFD_BUSY_XFER && cmd.accepted);
    c_wake: cover property ($fell(power_down));
endmodule

bind sfd_decoder sfd_decoder_assertions #(.ADDR_W(ADDR_W))
    i_sfd_decoder_assertions (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .link_sck(link_sck),
    .link_cs_n(link_cs_n), .link_si(link_si), .op_done(op_done),
    .cmd(cmd), .cmd_valid(cmd_valid), .addr(addr), .addr_valid(addr_valid),
    .cmd_exec(cmd_exec), .exec_op(exec_op), .busy(busy),
    .power_down(power_down)
);

// file: sfd_host_model.sv
// host model: frames commands onto the serial link in mode 0
`timescale 1ns/1ps
module sfd_host_model
(
    // serial link towards the decoder
    output logic link_sck,
    output logic link_cs_n,
    output logic link_si
);
    localparam int HALF = 6;

    initial {link_sck, link_cs_n, link_si} = 3'b010;

    task automatic xfer(input logic [31:0] f, input int gap);
        #(HALF / 2);
        link_cs_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            link_si = f[i];
            #(HALF);
            link_sck = 1'b1;
            #(HALF);
            link_sck = 1'b0;
            // slow host: sck parked low between bytes
            if (i % 8 == 0)
                #(gap * 2 * HALF);
        end
        // let the last byte cross
        #(8 * HALF);
        link_cs_n = 1'b1;
        // a released line must not keep showing the last bit
        link_si = ~link_si;
        #(8 * HALF);
    endtask
endmodule

// file: sfd_decoder_tb.sv
// self-checking bench for the serial flash command decoder
`timescale 1ns/1ps
module sfd_decoder_tb
    import sfd_pkg::*;
;
    localparam int AW = 18;
    logic          clk_sys, sys_rst, op_done, link_sck, link_cs_n, link_si;
    logic          cmd_valid, addr_valid, cmd_exec, power_down, exp_pd, hold;
    logic [AW-1:0] addr, q_addr[$];
    sfd_cmd_t      cmd, ec, q_cmd[$];
    sfd_op_t       exec_op, q_exec[$];
    sfd_busy_t     busy, exp_busy;
    int            err_total, compares, cyc;

    sfd_decoder #(.ADDR_W(AW)) i_sfd_decoder (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .link_sck(link_sck),
        .link_cs_n(link_cs_n), .link_si(link_si), .op_done(op_done),
        .cmd(cmd), .cmd_valid(cmd_valid), .addr(addr),
        .addr_valid(addr_valid), .cmd_exec(cmd_exec), .exec_op(exec_op),
        .busy(busy), .power_down(power_down)
    );
    sfd_host_model i_sfd_host_model (
        .link_sck(link_sck), .link_cs_n(link_cs_n), .link_si(link_si)
    );

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    function automatic sfd_grp_t grp_of(input sfd_op_t o);
        case (o)
            SFD_PAGE_READ, SFD_CONT_READ_OLD, SFD_CONT_READ_LF,
            SFD_CONT_READ_HF, SFD_PROT_READ, SFD_LOCK_READ, SFD_SEC_READ:
                return SFD_GRP_A;
            SFD_PAGE_ERASE, SFD_BLOCK_ERASE, SFD_SECTOR_ERASE, SFD_CHIP_ERASE:
                return SFD_GRP_B_ERASE;
            SFD_XFER, SFD_COMPARE, SFD_PROG_ERASE, SFD_PROG_NOERASE,
            SFD_PROG_THRU_BUF, SFD_REWRITE:
                return SFD_GRP_B_XFER;
            SFD_BUF_READ_LF, SFD_BUF_READ, SFD_BUF_WRITE, SFD_STATUS_READ,
            SFD_ID_READ:
                return SFD_GRP_C;
            SFD_PROT_ERASE, SFD_PROT_PROG, SFD_LOCKDOWN, SFD_SEC_PROG:
                return SFD_GRP_D;
            default:
                return SFD_GRP_OTHER;
        endcase
    endfunction

    function automatic logic [23:0] r();
        return 24'($urandom());
    endfunction

    task automatic done_pulse();
        @(posedge clk_sys);
        op_done <= 1'b1;
        @(posedge clk_sys);
        op_done <= 1'b0;
        exp_busy = SFD_IDLE;
        repeat (2) @(posedge clk_sys);
        chk("busy", SFD_IDLE, busy);
    endtask

    task automatic run(input logic [31:0] f, input sfd_op_t op,
                       input logic acc = 1'b1);
        sfd_grp_t   g;
        logic       ex;
        logic [2:0] d;
        g = grp_of(op);
        ex = acc && g != SFD_GRP_A && !(op inside {SFD_BUF_READ_LF,
             SFD_BUF_READ, SFD_STATUS_READ, SFD_ID_READ});
        d = op inside {SFD_CONT_READ_HF, SFD_BUF_READ} ? 3'h1 :
            op inside {SFD_PAGE_READ, SFD_CONT_READ_OLD} ? 3'h4 : 3'h0;
        q_cmd.push_back({op, g, d, acc});
        q_addr.push_back(f[AW-1:0]);
        if (ex)
        begin
            q_exec.push_back(op);
            exp_busy = g == SFD_GRP_B_ERASE ? SFD_BUSY_ERASE :
                       g == SFD_GRP_B_XFER ? SFD_BUSY_XFER :
                       g == SFD_GRP_D ? SFD_BUSY_PROT : exp_busy;
            exp_pd = op == SFD_POWER_DOWN ? 1'b1 :
                     op == SFD_RESUME ? 1'b0 : exp_pd;
        end
        i_sfd_host_model.xfer(f, $urandom_range(3));
        // next frame only after this one is fully answered
        for (int n = 0; n < 60 && q_cmd.size() + q_exec.size() > 0; n++)
            @(posedge clk_sys);
        chk("pending", 0, q_cmd.size() + q_addr.size() + q_exec.size());
        repeat (2) @(posedge clk_sys);
        chk("busy", exp_busy, busy);
        chk("power_down", exp_pd, power_down);
        if (!hold && exp_busy != SFD_IDLE)
            done_pulse();
    endtask

    always @(negedge clk_sys)
    begin
        cyc++;
        if (cmd_valid === 1'b1)
        begin
            ec = q_cmd.size() > 0 ? q_cmd.pop_front() : 'x;
            chk("op", ec.op, cmd.op);
            chk("accepted", ec.accepted, cmd.accepted);
            if (ec.accepted)
                chk("grp", ec.grp, cmd.grp);
            if (ec.accepted)
                chk("dummy", ec.dummy, cmd.dummy);
        end
        if (addr_valid === 1'b1)
            chk("addr", q_addr.size() > 0 ? q_addr.pop_front() : 'x, addr);
        if (cmd_exec === 1'b1)
            chk("exec_op", q_exec.size() > 0 ? q_exec.pop_front() : 'x,
                exec_op);
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        op_done = 1'b0;
        hold = 1'b0;
        exp_busy = SFD_IDLE;
        exp_pd = 1'b0;
        void'($urandom(84264));
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        run({8'h03, r()}, SFD_CONT_READ_LF);
        run({8'h0B, r()}, SFD_CONT_READ_HF);
        run({8'hD2, r()}, SFD_PAGE_READ);
        run({8'hE8, r()}, SFD_CONT_READ_OLD);
        run({8'hD1, r()}, SFD_BUF_READ_LF);
        run({8'hD4, r()}, SFD_BUF_READ);
        run({8'h83, r()}, SFD_PROG_ERASE);
        run({8'h88, r()}, SFD_PROG_NOERASE);
        run({8'h84, r()}, SFD_BUF_WRITE);
        run({8'h82, r()}, SFD_PROG_THRU_BUF);
        run({8'h81, r()}, SFD_PAGE_ERASE);
        run({8'h50, r()}, SFD_BLOCK_ERASE);
        run(32'h7C000000, SFD_SECTOR_ERASE);
        run(32'h7C94809A, SFD_CHIP_ERASE);
        run({8'h53, r()}, SFD_XFER);
        run({8'h60, r()}, SFD_COMPARE);
        run({8'h58, r()}, SFD_REWRITE);
        run({8'h32, r()}, SFD_PROT_READ);
        run({8'h35, r()}, SFD_LOCK_READ);
        run({8'h77, r()}, SFD_SEC_READ);
        run({8'hD7, r()}, SFD_STATUS_READ);
        run({8'h9F, r()}, SFD_ID_READ);
        run({8'h54, r()}, SFD_BUF_READ);
        run({8'h52, r()}, SFD_PAGE_READ);
        run({8'h68, r()}, SFD_CONT_READ_OLD);
        run({8'h57, r()}, SFD_STATUS_READ);
        run(32'h3D2A7FA9, SFD_PROT_EN);
        run(32'h3D2A7F9A, SFD_PROT_DIS);
        run(32'h3D2A7FCF, SFD_PROT_ERASE);
        run(32'h3D2A7FFC, SFD_PROT_PROG);
        run(32'h3D2A7F30, SFD_LOCKDOWN);
        run(32'h9B000000, SFD_SEC_PROG);
        run(32'h3D2A80A6, SFD_UNKNOWN, 1'b0);
        run({8'hFF, r()}, SFD_UNKNOWN, 1'b0);
        run({8'hAB, r()}, SFD_RESUME, 1'b0);
        run({8'hB9, r()}, SFD_POWER_DOWN);
        run({8'hD7, r()}, SFD_STATUS_READ, 1'b0);
        run({8'hAB, r()}, SFD_RESUME);
        hold = 1'b1;
        run({8'h81, r()}, SFD_PAGE_ERASE);
        run({8'hD4, r()}, SFD_BUF_READ);
        run({8'hD7, r()}, SFD_STATUS_READ);
        run({8'h9F, r()}, SFD_ID_READ);
        run({8'h03, r()}, SFD_CONT_READ_LF, 1'b0);
        run({8'h50, r()}, SFD_BLOCK_ERASE, 1'b0);
        run({8'h84, r()}, SFD_BUF_WRITE);
        done_pulse();
        run({8'h53, r()}, SFD_XFER);
        run({8'hD7, r()}, SFD_STATUS_READ);
        run({8'h9F, r()}, SFD_ID_READ);
        run({8'hD4, r()}, SFD_BUF_READ, 1'b0);
        run({8'h84, r()}, SFD_BUF_WRITE, 1'b0);
        done_pulse();
        run(32'h3D2A7FFC, SFD_PROT_PROG);
        run({8'hD7, r()}, SFD_STATUS_READ);
        run({8'h9F, r()}, SFD_ID_READ, 1'b0);
        done_pulse();
        wrap_up();
    end
endmodule
